// ### src/caw_params.svh
`ifndef CAW_PARAMS_SVH
`define CAW_PARAMS_SVH

// ==========================================================
// Register indices (byte address is four times the index)
`define CAW_IDX_CTRL    8'hd8
`define CAW_IDX_MODE    8'hd9
`define CAW_IDX_CPM2    8'hdc
`define CAW_IDX_ISTAT   8'he0
`define CAW_IDX_IMASK   8'he1
`define CAW_IDX_CNT_LO  8'he9
`define CAW_IDX_CPL2    8'heb
`define CAW_IDX_CNT_HI  8'hf9
`define CAW_IDX_CPH2    8'hfb

// ==========================================================
// Reset values
`define CAW_CTRL_RST    8'h00
`define CAW_MODE_RST    8'h40
`define CAW_CPM2_RST    8'h00
`define CAW_CPL2_RST    8'h00
`define CAW_CPH2_RST    8'h00
`define CAW_CNT_RST     8'h00
`define CAW_IRQ_RST     2'h0

// ==========================================================
// Field positions
`define CAW_CTRL_CF     7
`define CAW_CTRL_CR     6
`define CAW_CTRL_MODULE2_MATCH_FLAG   2
`define CAW_CPM2_ECOM   6
`define CAW_CPM2_MAT    3
`define CAW_CPM2_ECCF   0
`define CAW_IRQ_OVF     0
`define CAW_IRQ_MATCH   1

// ==========================================================
// Timebase divider counts
`define CAW_DIV12       4'hc
`define CAW_DIV4        4'h4
`define CAW_DIV8        4'h8

`endif

// ### src/caw_pkg.sv
package caw_pkg;

	// ==========================================================
	// Timebase select codes
	typedef enum logic [2:0] {
		CAW_TB_SYS_DIV12 = 3'h0,
		CAW_TB_SYS_DIV4  = 3'h1,
		CAW_TB_TIMER0    = 3'h2,
		CAW_TB_EXT_FALL  = 3'h3,
		CAW_TB_SYS       = 3'h4,
		CAW_TB_EXT_DIV8  = 3'h5,
		CAW_TB_RSVD6     = 3'h6,
		CAW_TB_RSVD7     = 3'h7
	} caw_tb_t;

	// ==========================================================
	// Mode register layout
	typedef struct packed {
		logic    idle_suspend;
		logic    watchdog_enable_bit;
		logic    watchdog_lock_bit;
		logic    unused;
		caw_tb_t timebase_select;
		logic    overflow_irq_mask;
	} caw_mode_t;

	// ==========================================================
	// Complete module state
	typedef struct packed {
		logic [1:0]  idle_s;
		logic [2:0]  t0_s;
		logic [2:0]  eci_s;
		logic [2:0]  ext_s;
		logic [3:0]  div12;
		logic [3:0]  div4;
		logic [3:0]  div8;
		logic [7:0]  cnt_lo;
		logic [7:0]  cnt_hi;
		logic        cf;
		logic        cr;
		logic        module2_match_flag;
		caw_mode_t   mode;
		logic [7:0]  cpm2;
		logic [7:0]  cpl2;
		logic [7:0]  cph2;
		logic [1:0]  istat;
		logic [1:0]  imask;
		logic        ack;
		logic [7:0]  rdata;
		logic        irq;
		logic        wdt_rst;
	} caw_state_t;

endpackage

// ### src/caw_watchdog.sv
// Implementation choice: the Wishbone register port.
`timescale 1ns/1ps
`include "caw_params.svh"

// Functional notes
// - Watchdog compares module2 high byte with counter high; low byte is offset.
// - Reset when counter low overflows while module2 high equals counter high.
// - While watchdog enabled, writing module2 high loads it with counter high plus offset.
// - Watchdog on forces counter running; run-control writes have no effect.
// - Run-control bit reads software value, zero if never set.
// - Counter byte writes ignored while watchdog enabled.
// - Timebase select and idle suspend frozen while watchdog enabled.
// - While enabled, module2 forced to compare mode; its mode writes ignored.
// - Writing one to module2 flag while enabled forces watchdog reset.
// - Enable bit or lock bit set enables the watchdog.
// - Lock bit keeps watchdog enabled until next system reset.
// - Unlocked, clearing enable bit disables watchdog and lifts restrictions.
// - After reset watchdog on, timebase clock/12, counter low and offset zero.
// - Timeout is 256 times offset plus 256 minus counter low.
// - With idle suspend set, counter and watchdog pause during idle.

module caw_watchdog #(
	parameter int ADDR_W = 10
) (
	input  wire logic              CLK_SYS,
	input  wire logic              SYS_RST,
	input  wire logic              WB_CYC_I,
	input  wire logic              WB_STB_I,
	input  wire logic              WB_WE_I,
	input  wire logic [ADDR_W-1:0] WB_ADR_I,
	input  wire logic [3:0]        WB_SEL_I,
	input  wire logic [31:0]       WB_DAT_I,
	output logic      [31:0]       WB_DAT_O,
	output logic                   WB_ACK_O,
	input  wire logic              CPU_IDLE,
	input  wire logic              TIMER0_OVF,
	input  wire logic              EXT_COUNT_IN,
	input  wire logic              EXT_CLK,
	output logic                   IRQ,
	output logic                   WDT_RST_REQ
);

	// ==========================================================
	// Helpers
	function automatic logic hit(input logic [ADDR_W-1:0] adr,
		input logic [7:0] idx);
		hit = (adr[ADDR_W-1:2] == idx);
	endfunction

	function automatic logic [3:0] div_next(input logic [3:0] cur,
		input logic [3:0] top);
		div_next = (cur == top - 4'h1) ? 4'h0 : cur + 4'h1;
	endfunction

	function automatic logic [7:0] cpm2_view(input logic [7:0] cur,
		input logic en);
		cpm2_view = cur;
		if (en) begin
			cpm2_view = 8'h00;
			cpm2_view[`CAW_CPM2_ECOM] = 1'b1;
			cpm2_view[`CAW_CPM2_MAT]  = 1'b1;
			cpm2_view[`CAW_CPM2_ECCF] = cur[`CAW_CPM2_ECCF];
		end
	endfunction

	caw_pkg::caw_state_t q;
	caw_pkg::caw_state_t s;

	logic       wd_en;
	logic       tick;
	logic       run;
	logic       lo_ovf;
	logic       fire;
	logic       match;
	logic       req;
	logic       wr;
	logic [7:0] wd;
	logic [7:0] rd;
	logic       t0_rise;
	logic       eci_fall;
	logic       ext_rise;
	logic       div12_end;
	logic       div4_end;
	logic       div8_end;
	logic       wrap16;
	logic       irq_stat;
	logic       irq_ovf;
	logic       wr_ctrl;
	logic       wr_mode;
	logic       wr_cpm2;
	logic       wr_cnt_lo;
	logic       wr_cnt_hi;
	logic       wr_cpl2;
	logic       wr_cph2;
	logic       wr_istat;
	logic       wr_imask;

	// ==========================================================
	// Next-state logic
	always_comb begin
		s = q;

		// ==========================================================
		// Defaults
		tick      = 1'b0;
		run       = 1'b0;
		lo_ovf    = 1'b0;
		fire      = 1'b0;
		match     = 1'b0;
		req       = 1'b0;
		wr        = 1'b0;
		wd        = 8'h00;
		t0_rise   = 1'b0;
		eci_fall  = 1'b0;
		ext_rise  = 1'b0;
		div12_end = 1'b0;
		div4_end  = 1'b0;
		div8_end  = 1'b0;
		wrap16    = 1'b0;
		irq_stat  = 1'b0;
		irq_ovf   = 1'b0;
		wr_ctrl   = 1'b0;
		wr_mode   = 1'b0;
		wr_cpm2   = 1'b0;
		wr_cnt_lo = 1'b0;
		wr_cnt_hi = 1'b0;
		wr_cpl2   = 1'b0;
		wr_cph2   = 1'b0;
		wr_istat  = 1'b0;
		wr_imask  = 1'b0;

		// ==========================================================
		// Input synchronisers and edge history
		s.idle_s = {q.idle_s[0], CPU_IDLE};
		s.t0_s   = {q.t0_s[1], q.t0_s[0], TIMER0_OVF};
		s.eci_s  = {q.eci_s[1], q.eci_s[0], EXT_COUNT_IN};
		s.ext_s  = {q.ext_s[1], q.ext_s[0], EXT_CLK};

		// ==========================================================
		// Source edges and prescaler ends
		t0_rise   = q.t0_s[1] & ~q.t0_s[2];
		eci_fall  = ~q.eci_s[1] & q.eci_s[2];
		ext_rise  = q.ext_s[1] & ~q.ext_s[2];
		div12_end = (q.div12 == `CAW_DIV12 - 4'h1);
		div4_end  = (q.div4 == `CAW_DIV4 - 4'h1);
		div8_end  = (q.div8 == `CAW_DIV8 - 4'h1);

		// ==========================================================
		// Prescalers
		s.div12 = div_next(q.div12, `CAW_DIV12);
		s.div4  = div_next(q.div4, `CAW_DIV4);
		if (ext_rise) begin
			s.div8 = div_next(q.div8, `CAW_DIV8);
		end

		wd_en = q.mode.watchdog_enable_bit
			| q.mode.watchdog_lock_bit;

		// ==========================================================
		// Timebase tick
		case (q.mode.timebase_select)
			caw_pkg::CAW_TB_SYS_DIV12: begin
				tick = div12_end;
			end
			caw_pkg::CAW_TB_SYS_DIV4: begin
				tick = div4_end;
			end
			caw_pkg::CAW_TB_TIMER0: begin
				tick = t0_rise;
			end
			caw_pkg::CAW_TB_EXT_FALL: begin
				tick = eci_fall;
			end
			caw_pkg::CAW_TB_SYS: begin
				tick = 1'b1;
			end
			caw_pkg::CAW_TB_EXT_DIV8: begin
				tick = ext_rise & div8_end;
			end
			default: begin
				tick = 1'b0;
			end
		endcase

		// ==========================================================
		// Counter run and idle suspend
		run = (q.cr | wd_en)
			& ~(q.mode.idle_suspend & q.idle_s[1]);
		lo_ovf = run & tick & (q.cnt_lo == 8'hff);
		wrap16 = run & tick & ({q.cnt_hi, q.cnt_lo} == 16'hffff);
		fire = lo_ovf & wd_en
			& (q.cph2 == q.cnt_hi);
		match = run & tick & ~wd_en
			& q.cpm2[`CAW_CPM2_ECOM] & q.cpm2[`CAW_CPM2_MAT]
			& ({q.cnt_hi, q.cnt_lo} == {q.cph2, q.cpl2});

		// ==========================================================
		// Bus request
		req = WB_CYC_I & WB_STB_I & ~q.ack;
		wr  = req & WB_WE_I & WB_SEL_I[0];
		wd  = WB_DAT_I[7:0];
		s.ack = req;

		// ==========================================================
		// Write strobes
		wr_ctrl   = wr & hit(WB_ADR_I, `CAW_IDX_CTRL);
		wr_mode   = wr & hit(WB_ADR_I, `CAW_IDX_MODE);
		wr_cpm2   = wr & hit(WB_ADR_I, `CAW_IDX_CPM2);
		wr_cnt_lo = wr & hit(WB_ADR_I, `CAW_IDX_CNT_LO);
		wr_cnt_hi = wr & hit(WB_ADR_I, `CAW_IDX_CNT_HI);
		wr_cpl2   = wr & hit(WB_ADR_I, `CAW_IDX_CPL2);
		wr_cph2   = wr & hit(WB_ADR_I, `CAW_IDX_CPH2);
		wr_istat  = wr & hit(WB_ADR_I, `CAW_IDX_ISTAT);
		wr_imask  = wr & hit(WB_ADR_I, `CAW_IDX_IMASK);

		// ==========================================================
		// Read mux
		rd = 8'h00;
		if (hit(WB_ADR_I, `CAW_IDX_CTRL)) begin
			rd[`CAW_CTRL_CF]   = q.cf;
			rd[`CAW_CTRL_CR]   = q.cr;
			rd[`CAW_CTRL_MODULE2_MATCH_FLAG] = q.module2_match_flag;
		end else if (hit(WB_ADR_I, `CAW_IDX_MODE)) begin
			rd = q.mode;
			rd[4] = 1'b0;
		end else if (hit(WB_ADR_I, `CAW_IDX_CPM2)) begin
			rd = cpm2_view(q.cpm2, wd_en);
		end else if (hit(WB_ADR_I, `CAW_IDX_ISTAT)) begin
			rd = {6'h00, q.istat};
		end else if (hit(WB_ADR_I, `CAW_IDX_IMASK)) begin
			rd = {6'h00, q.imask};
		end else if (hit(WB_ADR_I, `CAW_IDX_CNT_LO)) begin
			rd = q.cnt_lo;
		end else if (hit(WB_ADR_I, `CAW_IDX_CNT_HI)) begin
			rd = q.cnt_hi;
		end else if (hit(WB_ADR_I, `CAW_IDX_CPL2)) begin
			rd = q.cpl2;
		end else if (hit(WB_ADR_I, `CAW_IDX_CPH2)) begin
			rd = q.cph2;
		end
		if (req) begin
			s.rdata = rd;
		end

		// ==========================================================
		// Counter advance
		if (run && tick) begin
			{s.cnt_hi, s.cnt_lo} = {q.cnt_hi, q.cnt_lo} + 16'h0001;
		end

		// ==========================================================
		// Register writes
		s.wdt_rst = fire;

		// Control register
		if (wr_ctrl) begin
			s.cf   = wd[`CAW_CTRL_CF];
			s.cr   = wd[`CAW_CTRL_CR];
			s.module2_match_flag = wd[`CAW_CTRL_MODULE2_MATCH_FLAG];
			if (wd_en && wd[`CAW_CTRL_MODULE2_MATCH_FLAG]) begin
				s.wdt_rst = 1'b1;
			end
		end

		// Mode register
		if (wr_mode) begin
			s.mode.overflow_irq_mask = wd[0];
			s.mode.watchdog_lock_bit =
				q.mode.watchdog_lock_bit | wd[5];
			s.mode.watchdog_enable_bit =
				q.mode.watchdog_lock_bit | wd[6];
			if (!wd_en) begin
				s.mode.idle_suspend    = wd[7];
				s.mode.timebase_select = caw_pkg::caw_tb_t'(wd[3:1]);
			end
		end

		// Module 2 mode
		if (wr_cpm2 && !wd_en) begin
			s.cpm2 = wd;
		end

		// Counter bytes
		if (wr_cnt_lo && !wd_en) begin
			s.cnt_lo = wd;
		end
		if (wr_cnt_hi && !wd_en) begin
			s.cnt_hi = wd;
		end

		// Module 2 low byte, the offset
		if (wr_cpl2) begin
			s.cpl2 = wd;
			if (!wd_en) begin
				s.cpm2[`CAW_CPM2_ECOM] = 1'b0;
			end
		end

		// Module 2 high byte, the update register
		if (wr_cph2) begin
			if (wd_en) begin
				s.cph2 = 8'(q.cnt_hi + q.cpl2);
			end else begin
				s.cph2 = wd;
				s.cpm2[`CAW_CPM2_ECOM] = 1'b1;
			end
		end

		// Interrupt status and mask
		if (wr_istat) begin
			s.istat = q.istat & ~wd[1:0];
		end
		if (wr_imask) begin
			s.imask = wd[1:0];
		end

		// ==========================================================
		// Hardware flag sets win over software clears
		if (wrap16) begin
			s.cf = 1'b1;
			s.istat[`CAW_IRQ_OVF] = 1'b1;
		end
		if (match) begin
			s.module2_match_flag = 1'b1;
			s.istat[`CAW_IRQ_MATCH] = 1'b1;
		end

		// ==========================================================
		// Interrupt output
		irq_stat = |(s.istat & s.imask);
		irq_ovf  = s.cf & s.mode.overflow_irq_mask;
		s.irq    = irq_stat | irq_ovf;
	end

	// ==========================================================
	// State register
	always_ff @(posedge CLK_SYS) begin
		if (SYS_RST) begin
			q.idle_s  <= 2'h0;
			q.t0_s    <= 3'h0;
			q.eci_s   <= 3'h0;
			q.ext_s   <= 3'h0;
			q.div12   <= 4'h0;
			q.div4    <= 4'h0;
			q.div8    <= 4'h0;
			q.cnt_lo  <= `CAW_CNT_RST;
			q.cnt_hi  <= `CAW_CNT_RST;
			q.cf      <= 1'b0;
			q.cr      <= 1'b0;
			q.module2_match_flag    <= 1'b0;
			q.mode    <= caw_pkg::caw_mode_t'(`CAW_MODE_RST);
			q.cpm2    <= `CAW_CPM2_RST;
			q.cpl2    <= `CAW_CPL2_RST;
			q.cph2    <= `CAW_CPH2_RST;
			q.istat   <= `CAW_IRQ_RST;
			q.imask   <= `CAW_IRQ_RST;
			q.ack     <= 1'b0;
			q.rdata   <= 8'h00;
			q.irq     <= 1'b0;
			q.wdt_rst <= 1'b0;
		end else begin
			q <= s;
		end
	end

	// ==========================================================
	// Outputs
	assign WB_DAT_O    = {24'h000000, q.rdata};
	assign WB_ACK_O    = q.ack;
	assign IRQ         = q.irq;
	assign WDT_RST_REQ = q.wdt_rst;

endmodule

// ### sim/caw_watchdog_asserts.sv
`timescale 1ns/1ps
// ==========================================================
// Port checks
module caw_chk #(
	parameter int ADDR_W = 10
) (
	input wire logic              CLK_SYS,
	input wire logic              SYS_RST,
	input wire logic              WB_CYC_I,
	input wire logic              WB_STB_I,
	input wire logic              WB_WE_I,
	input wire logic [ADDR_W-1:0] WB_ADR_I,
	input wire logic [3:0]        WB_SEL_I,
	input wire logic [31:0]       WB_DAT_I,
	input wire logic [31:0]       WB_DAT_O,
	input wire logic              WB_ACK_O,
	input wire logic              IRQ,
	input wire logic              WDT_RST_REQ
);
	logic lk_reg;
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (SYS_RST);
	// Lock seen on the bus
	always_ff @(posedge CLK_SYS) begin
		if (SYS_RST)
			lk_reg <= 1'b0;
		else if (WB_CYC_I && WB_STB_I && !WB_ACK_O && WB_WE_I &&
			WB_SEL_I[0] && WB_ADR_I[9:2] == 8'hd9 && WB_DAT_I[5])
			lk_reg <= 1'b1;
	end
	sequence s_take;
		WB_CYC_I && WB_STB_I && !WB_ACK_O;
	endsequence
	sequence s_ans;
		WB_ACK_O ##1 !WB_ACK_O;
	endsequence
	property p_ack;
		s_take |=> s_ans;
	endproperty
	property p_no_ack;
		!(WB_CYC_I && WB_STB_I) |=> !WB_ACK_O;
	endproperty
	property p_pulse;
		WDT_RST_REQ |=> !WDT_RST_REQ;
	endproperty
	property p_hi0;
		WB_ACK_O |-> WB_DAT_O[31:8] == 24'h0;
	endproperty
	property p_hold;
		!WB_ACK_O |-> $stable(WB_DAT_O);
	endproperty
	property p_quiet;
		$fell(SYS_RST) |-> !IRQ && !WB_ACK_O && !WDT_RST_REQ;
	endproperty
	property p_unmap;
		s_take ##0 (!WB_WE_I && WB_ADR_I[9:2] == 8'h10)
			|=> WB_DAT_O == 32'h0;
	endproperty
	property p_force;
		s_take ##0 (lk_reg && WB_WE_I && WB_SEL_I[0] &&
			WB_ADR_I[9:2] == 8'hd8 && WB_DAT_I[2]) |-> ##[1:2] WDT_RST_REQ;
	endproperty
	a_ack: assert property (p_ack) else $error("ack not one pulse");
	a_no_ack: assert property (p_no_ack) else $error("ack unasked");
	a_pulse: assert property (p_pulse) else $error("reset pulse long");
	a_hi0: assert property (p_hi0) else $error("upper data set");
	a_hold: assert property (p_hold) else $error("data moved");
	a_quiet: assert property (p_quiet) else $error("busy after reset");
	a_unmap: assert property (p_unmap) else $error("unmapped nonzero");
	a_force: assert property (p_force) else $error("no forced reset");
endmodule

bind caw_watchdog caw_chk #(.ADDR_W(ADDR_W)) u_chk (
	.CLK_SYS(CLK_SYS), .SYS_RST(SYS_RST), .WB_CYC_I(WB_CYC_I),
	.WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I),
	.WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O),
	.WB_ACK_O(WB_ACK_O), .IRQ(IRQ), .WDT_RST_REQ(WDT_RST_REQ));

// ### sim/caw_watchdog_tb_top.sv
`timescale 1ns/1ps
// ==========================================================
// Bench
module caw_watchdog_tb_top;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        idle = 1'b0;
	logic        cyc = 1'b0;
	logic        stb = 1'b0;
	logic        we = 1'b0;
	logic [9:0]  adr = 10'h0;
	logic [3:0]  sel = 4'h1;
	logic [31:0] dat = 32'h0;
	logic [31:0] rdat;
	logic        ack;
	logic        irq;
	logic        wrst;
	logic [7:0]  q;
	int          n;
	int          failures = 0;
	int          cmp_count = 0;
	// Index, write data, read back
	logic [23:0] rows [10] = '{
		24'hf9_33_00,
		24'hd9_4e_40,
		24'hdc_00_48,
		24'hd8_00_00,
		24'h10_ff_00,
		24'hd9_08_00,
		24'hd9_08_08,
		24'hf9_12_12,
		24'he9_f0_f0,
		24'heb_01_01};

	initial begin
		forever #2.5 clk = ~clk;
	end

	caw_watchdog uut (.CLK_SYS(clk), .SYS_RST(rst), .WB_CYC_I(cyc),
		.WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel),
		.WB_DAT_I(dat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
		.CPU_IDLE(idle), .TIMER0_OVF(1'b0), .EXT_COUNT_IN(1'b0),
		.EXT_CLK(1'b0), .IRQ(irq), .WDT_RST_REQ(wrst));

	task print_verdict;
		$display("compares %0d failures %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task bad(input string m);
		failures++;
		$display("unexpected at %0t: %s", $time, m);
	endtask
	task chk8(input logic [7:0] g, input logic [7:0] e, input string m);
		cmp_count++;
		if (g !== e)
			bad(m);
	endtask
	task chkr(input int g, input int lo, input int hi, input string m);
		cmp_count++;
		if (g < lo || g > hi)
			bad(m);
	endtask
	task wb(input logic w, input logic [7:0] i, input logic [7:0] d,
		output logic [7:0] r);
		int k;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= {i, 2'b00};
		dat <= {24'h0, d};
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (ack !== 1'b1 && k < 20);
		if (k >= 20) begin
			bad("ack timeout");
			print_verdict;
		end
		r = rdat[7:0];
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	task wait_pulse(input int lim, output int c);
		c = 0;
		while (wrst !== 1'b1 && c < lim) begin
			@(posedge clk);
			c++;
		end
		if (c >= lim) begin
			bad("no reset pulse");
			print_verdict;
		end
	endtask
	task chk_irq(input logic e);
		@(negedge clk);
		chk8({7'h0, irq}, {7'h0, e}, "irq level");
	endtask
	task do_reset;
		rst <= 1'b1;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
	endtask

	initial begin
		do_reset;
		wb(1'b0, 8'hd8, 8'h0, q);
		chk8(q, 8'h00, "ctrl reset");
		wb(1'b0, 8'hd9, 8'h0, q);
		chk8(q, 8'h40, "mode reset");
		wb(1'b0, 8'heb, 8'h0, q);
		chk8(q, 8'h00, "offset reset");
		for (int j = 0; j < 10; j++) begin
			wb(1'b1, rows[j][23:16], rows[j][15:8], q);
			wb(1'b0, rows[j][23:16], 8'h0, q);
			chk8(q, rows[j][7:0], "table row");
		end
		$display("table done");
		wb(1'b1, 8'hd9, 8'h48, q);
		wb(1'b1, 8'hfb, 8'h00, q);
		wait_pulse(600, n);
		chkr(n, 262, 276, "timeout length");
		wb(1'b0, 8'hfb, 8'h0, q);
		chk8(q, 8'h13, "update value");
		wb(1'b1, 8'hd8, 8'h04, q);
		wait_pulse(4, n);
		chkr(n, 0, 3, "forced pulse");
		wb(1'b1, 8'hd9, 8'h60, q);
		wb(1'b1, 8'hd9, 8'h00, q);
		wb(1'b0, 8'hd9, 8'h0, q);
		chk8(q, 8'h68, "lock holds");
		wb(1'b1, 8'hd8, 8'h04, q);
		wait_pulse(4, n);
		chkr(n, 0, 3, "locked pulse");
		$display("watchdog done");
		do_reset;
		wait_pulse(3200, n);
		chkr(n, 3060, 3090, "default timeout");
		wb(1'b1, 8'hd9, 8'h00, q);
		wb(1'b1, 8'hd9, 8'h08, q);
		wb(1'b1, 8'he9, 8'hff, q);
		wb(1'b1, 8'hf9, 8'hff, q);
		wb(1'b1, 8'hd8, 8'h40, q);
		wb(1'b0, 8'hd8, 8'h0, q);
		chk8(q, 8'hc0, "wrap flag");
		wb(1'b1, 8'hd8, 8'h00, q);
		wb(1'b1, 8'he1, 8'h01, q);
		chk_irq(1'b1);
		wb(1'b1, 8'he1, 8'h00, q);
		chk_irq(1'b0);
		wb(1'b1, 8'he1, 8'h01, q);
		wb(1'b1, 8'he0, 8'h01, q);
		chk_irq(1'b0);
		$display("irq done");
		idle <= 1'b1;
		wb(1'b1, 8'hd9, 8'h88, q);
		wb(1'b1, 8'he9, 8'h00, q);
		wb(1'b1, 8'hf9, 8'h00, q);
		wb(1'b1, 8'hd8, 8'h40, q);
		wb(1'b0, 8'he9, 8'h0, q);
		chk8(q, 8'h00, "idle hold");
		idle <= 1'b0;
		wb(1'b0, 8'he9, 8'h0, q);
		wb(1'b0, 8'he9, 8'h0, q);
		chkr(q, 1, 8, "idle resume");
		$display("idle done");
		print_verdict;
	end
endmodule
